// *** src/wrs_host.sv ***
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
module wrs_host
   import wrs_pkg::*;
#(
   parameter logic [6:0] DEV_ID = WRS_DEV_ID
) (
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic [1:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output      logic [7:0] reg_rdata,
   wrs_bus_if.host         bus
);

   typedef struct packed {
      wrs_hstate_type st;
      wrs_step_type   step;
      logic [4:0]     qcnt;
      logic [1:0]     ph;
      logic [3:0]     bits;
      logic [7:0]     shreg;
      logic           rd_op;
      logic [1:0]     extra;
      logic           scl_rel;
      logic           sda_rel;
      logic           ack_in;
      logic [7:0]     wdata;
      logic [7:0]     rdata;
      logic           done;
      logic           nack;
      logic [7:0]     rd_out;
   } wrs_host_type;

   wrs_host_type r;
   wrs_host_type next_r;
   logic         busy;
   logic         qtick;
   logic         rx_byte;

   assign busy    = r.st != H_IDLE;
   assign qtick   = busy && r.qcnt == WRS_QUARTER_CYC - 5'h1;
   assign rx_byte = r.step == S_RDATA;

   always_comb begin
      next_r        = r;
      next_r.rd_out = 8'h00;
      if (reg_rd) begin
         if (reg_addr == WRS_REG_WDATA) begin
            next_r.rd_out = r.wdata;
         end else if (reg_addr == WRS_REG_STATUS) begin
            next_r.rd_out = {5'h00, r.nack, r.done, busy};
         end else if (reg_addr == WRS_REG_RDATA) begin
            next_r.rd_out = r.rdata;
         end
      end
      if (reg_wr) begin
         if (reg_addr == WRS_REG_CTRL) begin
            // Commands while busy are dropped
            if (!busy && (reg_wdata[WRS_CTRL_GO_WR] || reg_wdata[WRS_CTRL_GO_RD])) begin
               next_r.st    = H_START;
               next_r.step  = S_IDW;
               next_r.rd_op = reg_wdata[WRS_CTRL_GO_RD];
               next_r.extra = reg_wdata[WRS_CTRL_EXTRA_H:WRS_CTRL_EXTRA_L];
               next_r.done  = 1'h0;
               next_r.nack  = 1'h0;
               next_r.ph    = 2'h0;
               next_r.qcnt  = 5'h00;
               next_r.shreg = {DEV_ID, WRS_DIR_WRITE};
            end
         end else if (reg_addr == WRS_REG_WDATA) begin
            next_r.wdata = reg_wdata;
         end
      end
      if (busy) begin
         next_r.qcnt = qtick ? 5'h00 : r.qcnt + 5'h01;
      end
      if (qtick) begin
         next_r.ph = r.ph + 2'h1;
         case (r.st)
            H_START: begin
               // Also serves as repeated START from SCL low
               case (r.ph)
                  2'h0: next_r.sda_rel = 1'h1;
                  2'h1: next_r.scl_rel = 1'h1;
                  2'h2: next_r.sda_rel = 1'h0;
                  default: begin
                     next_r.scl_rel = 1'h0;
                     next_r.st      = H_BYTE;
                     next_r.bits    = 4'h0;
                  end
               endcase
            end
            H_BYTE: begin
               case (r.ph)
                  2'h0: begin
                     if (r.bits == WRS_BYTE_BITS) begin
                        // Ack further bytes, refuse the last one
                        next_r.sda_rel = !(rx_byte && r.extra != 2'h0);
                     end else begin
                        next_r.sda_rel = rx_byte | r.shreg[7];
                     end
                  end
                  2'h1: next_r.scl_rel = 1'h1;
                  2'h2: begin
                     next_r.ack_in = bus.sda;
                     if (r.bits != WRS_BYTE_BITS) begin
                        next_r.shreg = {r.shreg[6:0], bus.sda};
                     end
                  end
                  default: begin
                     next_r.scl_rel = 1'h0;
                     next_r.bits    = r.bits + 4'h1;
                     if (r.bits == WRS_BYTE_BITS) begin
                        next_r.bits = 4'h0;
                        if (!rx_byte && r.ack_in) begin
                           next_r.nack = 1'h1;
                           next_r.st   = H_STOP;
                        end else begin
                           case (r.step)
                              S_IDW: begin
                                 next_r.step  = S_ADDR;
                                 next_r.shreg = WRS_ADDR_WIPER;
                              end
                              S_ADDR: begin
                                 if (r.rd_op) begin
                                    next_r.step  = S_IDR;
                                    next_r.st    = H_START;
                                    next_r.shreg = {DEV_ID, WRS_DIR_READ};
                                 end else begin
                                    next_r.step  = S_WDATA;
                                    next_r.shreg = r.wdata;
                                 end
                              end
                              S_IDR: next_r.step = S_RDATA;
                              S_RDATA: begin
                                 next_r.rdata = r.shreg;
                                 if (r.extra != 2'h0) begin
                                    next_r.extra = r.extra - 2'h1;
                                 end else begin
                                    next_r.st = H_STOP;
                                 end
                              end
                              default: next_r.st = H_STOP;
                           endcase
                        end
                     end
                  end
               endcase
            end
            H_STOP: begin
               case (r.ph)
                  2'h0: next_r.sda_rel = 1'h0;
                  2'h1: next_r.scl_rel = 1'h1;
                  2'h2: next_r.sda_rel = 1'h1;
                  default: begin
                     next_r.st   = H_IDLE;
                     next_r.done = 1'h1;
                  end
               endcase
            end
            default: next_r.st = H_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         r         <= '0;
         r.st      <= H_IDLE;
         r.step    <= S_IDW;
         r.scl_rel <= 1'h1;
         r.sda_rel <= 1'h1;
      end else begin
         r <= next_r;
      end
   end

   assign reg_rdata         = r.rd_out;
   assign bus.host_scl_o    = 1'h0;
   assign bus.host_scl_oe_n = r.scl_rel;
   assign bus.host_sda_o    = 1'h0;
   assign bus.host_sda_oe_n = r.sda_rel;

endmodule

// *** src/wrs_pkg.sv ***
package wrs_pkg;
   localparam int unsigned WRS_CLK_NS         = 100;
   localparam int unsigned WRS_SCL_QUARTER_NS = 2500;
   // Quarter of a 100 kHz SCL period, rounded down
   localparam logic [4:0] WRS_QUARTER_CYC = 5'(WRS_SCL_QUARTER_NS / WRS_CLK_NS);
   // Arbitrary value, not tied to any real part
   localparam logic [6:0] WRS_DEV_ID      = 7'h3A;
   localparam logic       WRS_DIR_WRITE   = 1'h0;
   localparam logic       WRS_DIR_READ    = 1'h1;
   localparam logic [7:0] WRS_ADDR_WIPER  = 8'h00;
   localparam logic [7:0] WRS_WIPER_RESET = 8'h80;
   localparam logic [3:0] WRS_BYTE_BITS   = 4'h8;
   // Controller register indices
   localparam logic [1:0] WRS_REG_CTRL    = 2'h0;
   localparam logic [1:0] WRS_REG_WDATA   = 2'h1;
   localparam logic [1:0] WRS_REG_STATUS  = 2'h2;
   localparam logic [1:0] WRS_REG_RDATA   = 2'h3;
   // Control register field positions
   localparam int unsigned WRS_CTRL_GO_WR   = 0;
   localparam int unsigned WRS_CTRL_GO_RD   = 1;
   localparam int unsigned WRS_CTRL_EXTRA_L = 2;
   localparam int unsigned WRS_CTRL_EXTRA_H = 3;

   typedef enum logic [2:0] {D_IDLE, D_RX, D_ACK, D_TX, D_TXACK, D_WAIT} wrs_dstate_type;
   typedef enum logic [1:0] {G_ID, G_ADDR, G_DATA, G_DONE} wrs_stage_type;
   typedef enum logic [1:0] {H_IDLE, H_START, H_BYTE, H_STOP} wrs_hstate_type;
   typedef enum logic [2:0] {S_IDW, S_ADDR, S_WDATA, S_IDR, S_RDATA} wrs_step_type;
endpackage

// *** src/wrs_bus_if.sv ***
`timescale 1ns/1ps
interface wrs_bus_if;
   logic host_scl_o;
   logic host_scl_oe_n;
   logic host_sda_o;
   logic host_sda_oe_n;
   logic dev_sda_o;
   logic dev_sda_oe_n;
   logic scl;
   logic sda;

   // Open-drain wired AND with pull-up
   assign scl = host_scl_oe_n | host_scl_o;
   assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

   modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
   modport host (input scl, input sda, output host_scl_o, output host_scl_oe_n,
                 output host_sda_o, output host_sda_oe_n);
endinterface

// *** src/wrs_device.sv ***
`timescale 1ns/1ps
module wrs_device
   import wrs_pkg::*;
#(
   parameter logic [6:0] DEV_ID = WRS_DEV_ID
) (
   input  wire logic       clk,
   input  wire logic       arst_n,
   wrs_bus_if.device       bus,
   output      logic [7:0] wiper_position,
   output      logic       wiper_written
);

   typedef struct packed {
      wrs_dstate_type st;
      wrs_stage_type  stage;
      logic           scl_p;
      logic           sda_p;
      logic [3:0]     bits;
      logic [7:0]     shreg;
      logic           addr_ok;
      logic           to_tx;
      logic           mack;
      logic           sda_rel;
      logic [7:0]     wiper;
      logic           wr_pulse;
   } wrs_dev_type;

   wrs_dev_type r;
   wrs_dev_type next_r;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_det;
   logic        stop_det;

   // Pins are synchronous to clk; one sample of history is enough
   assign scl_rise  = bus.scl & ~r.scl_p;
   assign scl_fall  = ~bus.scl & r.scl_p;
   assign start_det = bus.scl & r.scl_p & r.sda_p & ~bus.sda;
   assign stop_det  = bus.scl & r.scl_p & ~r.sda_p & bus.sda;

   always_comb begin
      next_r          = r;
      next_r.scl_p    = bus.scl;
      next_r.sda_p    = bus.sda;
      next_r.wr_pulse = 1'h0;
      if (stop_det) begin
         // Abort anywhere; a partial data byte never reaches the wiper
         next_r.st      = D_IDLE;
         next_r.sda_rel = 1'h1;
         next_r.addr_ok = 1'h0;
      end else if (start_det) begin
         next_r.st      = D_RX;
         next_r.stage   = G_ID;
         next_r.bits    = 4'h0;
         next_r.sda_rel = 1'h1;
      end else begin
         case (r.st)
            D_RX: begin
               if (scl_rise && r.bits != WRS_BYTE_BITS) begin
                  next_r.shreg = {r.shreg[6:0], bus.sda};
                  next_r.bits  = r.bits + 4'h1;
               end else if (scl_fall && r.bits == WRS_BYTE_BITS) begin
                  next_r.st = D_WAIT;
                  case (r.stage)
                     G_ID: begin
                        if (r.shreg[7:1] == DEV_ID) begin
                           if (r.shreg[0] == WRS_DIR_WRITE) begin
                              next_r.st      = D_ACK;
                              next_r.sda_rel = 1'h0;
                              next_r.stage   = G_ADDR;
                              next_r.to_tx   = 1'h0;
                           end else if (r.addr_ok) begin
                              next_r.st      = D_ACK;
                              next_r.sda_rel = 1'h0;
                              next_r.to_tx   = 1'h1;
                           end
                        end
                     end
                     G_ADDR: begin
                        if (r.shreg == WRS_ADDR_WIPER) begin
                           next_r.st      = D_ACK;
                           next_r.sda_rel = 1'h0;
                           next_r.addr_ok = 1'h1;
                           next_r.stage   = G_DATA;
                        end
                     end
                     G_DATA: begin
                        // Id and address already checked to get here
                        next_r.wiper    = r.shreg;
                        next_r.wr_pulse = 1'h1;
                        next_r.st       = D_ACK;
                        next_r.sda_rel  = 1'h0;
                        next_r.stage    = G_DONE;
                     end
                     default: begin
                        next_r.st = D_WAIT;
                     end
                  endcase
               end
            end
            D_ACK: begin
               if (scl_fall) begin
                  next_r.sda_rel = 1'h1;
                  next_r.bits    = 4'h0;
                  if (r.to_tx) begin
                     next_r.st      = D_TX;
                     next_r.sda_rel = r.wiper[7];
                     next_r.shreg   = {r.wiper[6:0], 1'h0};
                     next_r.bits    = 4'h1;
                  end else if (r.stage == G_DONE) begin
                     next_r.st = D_WAIT;
                  end else begin
                     next_r.st = D_RX;
                  end
               end
            end
            D_TX: begin
               if (scl_fall) begin
                  if (r.bits == WRS_BYTE_BITS) begin
                     next_r.sda_rel = 1'h1;
                     next_r.st      = D_TXACK;
                  end else begin
                     next_r.sda_rel = r.shreg[7];
                     next_r.shreg   = {r.shreg[6:0], 1'h0};
                     next_r.bits    = r.bits + 4'h1;
                  end
               end
            end
            D_TXACK: begin
               if (scl_rise) begin
                  next_r.mack = ~bus.sda;
               end else if (scl_fall) begin
                  if (r.mack) begin
                     // Register may change between bytes; resample it
                     next_r.st      = D_TX;
                     next_r.sda_rel = r.wiper[7];
                     next_r.shreg   = {r.wiper[6:0], 1'h0};
                     next_r.bits    = 4'h1;
                  end else begin
                     next_r.st      = D_WAIT;
                     next_r.sda_rel = 1'h1;
                  end
               end
            end
            default: begin
               next_r.sda_rel = 1'h1;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         r          <= '0;
         r.st       <= D_IDLE;
         r.stage    <= G_ID;
         r.scl_p    <= 1'h1;
         r.sda_p    <= 1'h1;
         r.sda_rel  <= 1'h1;
         r.wiper    <= WRS_WIPER_RESET;
      end else begin
         r <= next_r;
      end
   end

   assign bus.dev_sda_o    = 1'h0;
   assign bus.dev_sda_oe_n = r.sda_rel;
   assign wiper_position   = r.wiper;
   assign wiper_written    = r.wr_pulse;

endmodule

// *** bench/wrs_bus_properties.sv ***
`timescale 1ns/1ps
module wrs_bus_properties (
   input wire logic       clk,
   input wire logic       arst_n,
   input wire logic       scl,
   input wire logic       sda,
   input wire logic       host_sda_oe_n,
   input wire logic       dev_sda_oe_n,
   input wire logic [7:0] wiper_position,
   input wire logic       wiper_written
);
   logic       prev_scl;
   logic       prev_sda;
   logic       dir;
   logic       ended;
   logic [7:0] rise_cnt;
   logic [7:0] low_cnt;
   logic       rise;
   logic       start;
   logic       rd_bit;
   logic       rd_resp;
   assign rise    = scl & ~prev_scl;
   assign start   = scl & prev_scl & prev_sda & ~sda;
   assign rd_bit  = dir & ~ended & (rise_cnt > 8'h08) & (rise_cnt % 8'h09 != 8'h08);
   assign rd_resp = dir & ~ended & (rise_cnt > 8'h08) & (rise_cnt % 8'h09 == 8'h08);
   // Count restarts at each START, so a repeated START opens a fresh frame
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         prev_scl <= 1'h1;
         prev_sda <= 1'h1;
         dir      <= 1'h0;
         ended    <= 1'h0;
         rise_cnt <= 8'h00;
         low_cnt  <= 8'h00;
      end else begin
         prev_scl <= scl;
         prev_sda <= sda;
         low_cnt  <= scl ? 8'h00 : low_cnt + 8'h01;
         if (start) begin
            rise_cnt <= 8'h00;
            dir      <= 1'h0;
            ended    <= 1'h0;
         end else if (rise) begin
            rise_cnt <= rise_cnt + 8'h01;
            if (rise_cnt == 8'h07) begin
               dir <= sda;
            end
            // Master not-ack ends the data phase
            if (rd_resp && sda) begin
               ended <= 1'h1;
            end
         end
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   reset_preset_a: assert property ($rose(arst_n) |-> wiper_position == 8'h80)
      else $error("wiper not at preset after reset");
   device_ack_a: assert property (rise && (rise_cnt == 8'h08 || (!dir &&
      (rise_cnt == 8'h11 || rise_cnt == 8'h1A))) |-> !dev_sda_oe_n)
      else $error("device did not acknowledge");
   read_bits_a: assert property (rise && rd_bit |-> host_sda_oe_n &&
      sda == wiper_position[3'h7 - 3'(rise_cnt % 8'h09)])
      else $error("read bit differs from wiper");
   master_resp_a: assert property (rise && rd_resp |-> dev_sda_oe_n)
      else $error("device holds sda in master response");
   commit_count_a: assert property (wiper_written |-> rise_cnt == 8'h1A && !dir)
      else $error("commit at wrong pulse count");
   commit_fall_a: assert property (wiper_written |-> !scl && low_cnt inside {[8'h01:8'h06]})
      else $error("commit not after scl fall");
   wiper_change_a: assert property ($changed(wiper_position) |-> ##[0:2] wiper_written)
      else $error("wiper changed without commit");
   stop_idle_a: assert property (scl && prev_scl && !prev_sda && sda |-> dev_sda_oe_n[*8])
      else $error("device active after stop");
   dev_edge_a: assert property ($changed(dev_sda_oe_n) |-> !scl && !$past(scl))
      else $error("device sda moved while scl high");
endmodule

// *** bench/wiper_register_i2c_slave_test.sv ***
`timescale 1ns/1ps
module wiper_register_i2c_slave_test
   import wrs_pkg::*;
();
   logic        clk;
   logic        arst_n;
   logic [1:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  reg_rdata;
   logic [7:0]  reg_rdata2;
   logic [7:0]  wiper;
   logic [7:0]  wiper2;
   logic        written;
   logic [31:0] rnd;
   logic [7:0]  d;
   logic [7:0]  st;
   logic [7:0]  st2;
   int          error_cnt;
   int          comparisons;
   int          writes;
   int          pulses;
   wrs_bus_if bus ();
   wrs_bus_if bus2 ();
   wrs_device u_wrs_device (.clk(clk), .arst_n(arst_n), .bus(bus.device),
      .wiper_position(wiper), .wiper_written(written));
   wrs_host u_wrs_host (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus(bus.host));
   // Second pair: host calls a foreign id, so its device must stay silent
   wrs_device u_wrs_device_2 (.clk(clk), .arst_n(arst_n), .bus(bus2.device),
      .wiper_position(wiper2), .wiper_written());
   wrs_host #(.DEV_ID(WRS_DEV_ID ^ 7'h01)) u_wrs_host_2 (.clk(clk), .arst_n(arst_n),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata2), .bus(bus2.host));
   wrs_bus_properties u_wrs_bus_properties (.clk(clk), .arst_n(arst_n), .scl(bus.scl),
      .sda(bus.sda), .host_sda_oe_n(bus.host_sda_oe_n), .dev_sda_oe_n(bus.dev_sda_oe_n),
      .wiper_position(wiper), .wiper_written(written));
   initial begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) if (written === 1'h1) pulses++;
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic logic [7:0] status_exp(input logic nack);
      return {5'h00, nack, 1'h1, 1'h0};
   endfunction
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic reg_write(input logic [1:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= 1'h1;
      @(posedge clk);
      reg_wr <= 1'h0;
   endtask
   task automatic reg_read(input logic [1:0] a, output logic [7:0] v, output logic [7:0] v2);
      @(posedge clk);
      reg_addr <= a;
      reg_rd   <= 1'h1;
      @(posedge clk);
      reg_rd <= 1'h0;
      #1;
      v  = reg_rdata;
      v2 = reg_rdata2;
   endtask
   // Poll bound covers the longest read with margin
   task automatic wait_idle();
      int n;
      n = 0;
      reg_read(WRS_REG_STATUS, st, st2);
      while (st[0] !== 1'h0 && n < 6000) begin
         reg_read(WRS_REG_STATUS, st, st2);
         n++;
      end
      check("busy", st & 8'h01, 8'h00);
   endtask
   task automatic run_read(input logic [7:0] exp, input logic [1:0] extra);
      logic [7:0] rd;
      logic [7:0] rd2;
      reg_write(WRS_REG_CTRL, {4'h0, extra, 2'h2});
      wait_idle();
      check("rstatus", st, status_exp(1'h0));
      check("rnack2", st2 & 8'h04, 8'h04);
      reg_read(WRS_REG_RDATA, rd, rd2);
      check("rdata", rd, exp);
      // Repeated START lands one bit into a fresh byte; wiper must hold
      check("rwiper", wiper, exp);
   endtask
   task automatic print_verdict();
      $display("Errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      #9_000_000;
      error_cnt++;
      print_verdict();
   end
   initial begin
      arst_n    = 1'h0;
      reg_addr  = 2'h0;
      reg_wdata = 8'h00;
      reg_wr    = 1'h0;
      reg_rd    = 1'h0;
      rnd       = 32'hE6CA;
      repeat (12) @(posedge clk);
      arst_n <= 1'h1;
      @(posedge clk);
      #1;
      check("preset", wiper, 8'h80);
      run_read(8'h80, 2'h0);
      for (int i = 0; i < 6; i++) begin
         rnd = xorshift(rnd);
         d = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : rnd[7:0];
         reg_write(WRS_REG_WDATA, d);
         reg_write(WRS_REG_CTRL, 8'h01);
         writes++;
         wait_idle();
         check("status", st, status_exp(1'h0));
         check("nack2", st2 & 8'h04, 8'h04);
         check("wiper", wiper, d);
         check("wiper2", wiper2, 8'h80);
         run_read(d, 2'(i));
      end
      check("pulses", 8'(pulses), 8'(writes));
      @(posedge clk);
      arst_n <= 1'h0;
      @(posedge clk);
      arst_n <= 1'h1;
      @(posedge clk);
      #1;
      check("represet", wiper, 8'h80);
      print_verdict();
   end
endmodule
